/* hsc_consts.svh */
// constants for the home seek completion block: offsets, field values, timing
// assumes a 32-bit classic wishbone slave and a 25 MHz system clock
`ifndef HSC_CONSTS_SVH
`define HSC_CONSTS_SVH
// register byte offsets
`define HSC_ADR_CMD    8'h00
`define HSC_ADR_CFG    8'h04
`define HSC_ADR_STAT   8'h08
`define HSC_ADR_MASK   8'h0c
`define HSC_ADR_STATE  8'h10
`define HSC_ADR_CPOS   8'h14
`define HSC_ADR_FPOS   8'h18
`define HSC_ADR_SOFT_LIMIT_POSITIVE   8'h1c
`define HSC_ADR_SOFT_LIMIT_NEGATIVE   8'h20
`define HSC_ADR_PRESET 8'h24
// command register bits (write one to act)
`define HSC_CMD_SEEKP  0
`define HSC_CMD_SEEKN  1
`define HSC_CMD_DEVCLR 2
// field values
`define HSC_TYPE_MAX   4'hc
`define HSC_TYPE_SLESS 4'hc
`define HSC_ENC_NONE   2'h0
`define HSC_ENC_DRV    2'h1
`define HSC_ENC_EXT    2'h2
`define HSC_DCL_OWN    2'h0
`define HSC_DCL_BOTH   2'h1
`define HSC_DCL_NONE   2'h2
// reset values
`define HSC_CFG_RST    11'h000
`define HSC_PRESET_RST 16'h0010
`define HSC_SOFT_LIMIT_POSITIVE_RST   32'h7fff_ffff
`define HSC_SOFT_LIMIT_NEGATIVE_RST   32'h8000_0000
// timing: driver clear pulse width
`define HSC_CLK_NS     40
`define HSC_DCL_NS     1000
`define HSC_DCL_CYC    8'((`HSC_DCL_NS + `HSC_CLK_NS - 1) / `HSC_CLK_NS)
`endif

/* hsc_drv_model.sv */
// driver and encoder model: turns commanded steps into feedback position
// assumes the controller drives clear and preset outputs and the bench drives step and direction
`timescale 1ns/100ps
module hsc_drv_model (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // from the controller (clear, preset, feedback clear) and the bench (step, direction)
  input  wire logic        i_step,
  input  wire logic        i_dir,
  input  wire logic        i_dcl,
  input  wire logic        i_preset,
  input  wire logic        i_fb_clear,
  // bench stimulus: timing kicks and load slip
  input  wire logic [2:0]  i_z_kick,
  input  wire logic [7:0]  i_slip,
  // to the controller and the bench
  output logic [31:0]      o_fb_pos,
  output logic [2:0]       o_tim,
  output logic [7:0]       o_dcl_n,
  output logic [7:0]       o_dcl_len,
  output logic [7:0]       o_pre_n,
  output logic [7:0]       o_pre_len
);
  logic [2:0] t1_r, t2_r;
  logic [7:0] dc_r, pc_r;
  // feedback counter, timing lines held three cycles, pulse width meters
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      {o_fb_pos, o_tim, t1_r, t2_r, dc_r, pc_r} <= '0;
      {o_dcl_n, o_dcl_len, o_pre_n, o_pre_len} <= '0;
    end else begin
      o_fb_pos <= i_fb_clear ? 32'h0 : o_fb_pos + {24'h0, i_slip}
                  + (i_step ? (i_dir ? 32'h1 : 32'hffff_ffff) : 32'h0);
      t1_r  <= i_z_kick;
      t2_r  <= t1_r;
      o_tim <= i_z_kick | t1_r | t2_r;
      dc_r  <= i_dcl ? dc_r + 8'h1 : 8'h0;
      pc_r  <= i_preset ? pc_r + 8'h1 : 8'h0;
      if (!i_dcl && dc_r != 8'h0) begin
        o_dcl_n   <= o_dcl_n + 8'h1;
        o_dcl_len <= dc_r;
      end
      if (!i_preset && pc_r != 8'h0) begin
        o_pre_n   <= o_pre_n + 8'h1;
        o_pre_len <= pc_r;
      end
    end
  end
endmodule : hsc_drv_model

/* hsc_home_ctrl.sv */
// home seek completion logic with a classic wishbone register slave
// assumes a seek engine that reports home found, limits and motion done
`timescale 1ns/100ps
`include "hsc_consts.svh"
module hsc_home_ctrl (
  // clock and reset
  input  wire logic                i_clock,
  input  wire logic                i_rst,
  // register bus
  input  wire hsc_pkg::hsc_wb_req_t i_wb,
  output logic                     o_wb_ack,
  output logic [31:0]              o_wb_dat,
  output logic                     o_irq,
  // seek engine and motion
  input  wire logic                i_home_found,
  input  wire logic                i_limit_found,
  input  wire logic                i_motion_done,
  input  wire logic                i_panic_stop,
  input  wire logic                i_current_off,
  input  wire logic                i_cmd_step,
  input  wire logic                i_cmd_dir,
  input  wire logic [31:0]         i_fb_pos,
  input  wire hsc_pkg::hsc_tim_in_t i_tim,
  output logic                     o_seek_start,
  output logic                     o_seek_dir,
  // driver and system outputs
  output logic                     o_at_home,
  output logic                     o_driver_pos_reset,
  output logic                     o_driver_alarm_dev_clear_out,
  output logic                     o_feedback_clear,
  output logic                     o_soft_limit_pos,
  output logic                     o_soft_limit_neg,
  output logic                     o_system_alarm
);
  import hsc_pkg::*;

  // address compare on word index
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction : hit

  // byte-lane write merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction : merge

  // odd types below 12 need the timing signal
  function automatic logic needs_tim(input logic [3:0] t);
    return t[0] && (t < `HSC_TYPE_MAX);
  endfunction : needs_tim

  hsc_cfg_t    cfg_r, cfg_nxt;
  hsc_evt_t    stat_r, stat_nxt, ev, mask_r;
  hsc_state_t  st_r, st_nxt;
  logic [31:0] cpos_r, cpos_nxt, soft_limit_positive_r, soft_limit_negative_r, rdata;
  logic [15:0] plen_r, pcnt_r, pcnt_nxt;
  logic [7:0]  dcnt_r, dcnt_nxt;
  logic        hv_r, hv_nxt;
  logic        ts1_r, ts2_r, ts3_r;
  logic [31:0] cfg_m;

  // bus request decode
  wire req    = i_wb.cyc & i_wb.stb & ~o_wb_ack;
  wire wr     = req & i_wb.we;
  wire rd     = req & ~i_wb.we;
  wire cmd_wr = wr & hit(i_wb.adr, `HSC_ADR_CMD) & i_wb.sel[0];
  wire [31:0] wdat = i_wb.dat;
  assign cfg_m = merge({21'h0, cfg_r}, wdat, i_wb.sel);
  wire [31:0] mask_m = merge({28'h0, mask_r}, wdat, i_wb.sel);
  wire [31:0] plen_m = merge({16'h0, plen_r}, wdat, i_wb.sel);

  // timing source select and synchroniser
  wire tim_raw = cfg_r.tim_sel ? i_tim.single :
                 (cfg_r.enc_sel == `HSC_ENC_DRV) ? i_tim.diff :
                 (cfg_r.enc_sel == `HSC_ENC_EXT) ? i_tim.ext_z : 1'b0;
  wire tim_edge = ts2_r & ~ts3_r;

  // seek start, alarm and detection
  wire tim_need = needs_tim(cfg_r.home_type);
  wire no_src   = (cfg_r.enc_sel == `HSC_ENC_NONE) & ~cfg_r.tim_sel;
  wire seek_req = cmd_wr & (wdat[`HSC_CMD_SEEKP] | wdat[`HSC_CMD_SEEKN]) & (st_r == ST_IDLE);
  wire alarm_ev = seek_req & no_src & tim_need;
  wire seek_go  = seek_req & ~alarm_ev;
  wire det_ev   = ((st_r == ST_SEEK) & i_home_found & ~tim_need) |
                  ((st_r == ST_TIM) & tim_edge);
  wire seeking  = st_r != ST_IDLE;
  wire do_pre   = cfg_r.pos_read_en & (cfg_r.home_type != `HSC_TYPE_SLESS);
  wire finish   = ((st_r == ST_MOVE) & i_motion_done & ~do_pre & ~i_panic_stop) |
                  ((st_r == ST_PRESET) & (pcnt_r <= 16'h0001) & ~i_panic_stop);
  wire devclr   = cmd_wr & wdat[`HSC_CMD_DEVCLR];

  // deviation clear selection
  wire sel_none = cfg_r.dcl_sel == `HSC_DCL_NONE;
  wire stop_ev  = i_limit_found | i_panic_stop;
  wire own_clr  = (det_ev | stop_ev) & ~sel_none;
  wire drv_clr  = (det_ev & (cfg_r.dcl_sel == `HSC_DCL_BOTH)) |
                  (stop_ev & ~sel_none);

  // sequence control
  always_comb begin
    st_nxt   = st_r;
    pcnt_nxt = pcnt_r;
    unique case (st_r)
      ST_IDLE:   if (seek_go) st_nxt = ST_SEEK;
      ST_SEEK:   if (i_home_found) st_nxt = tim_need ? ST_TIM : ST_MOVE;
      ST_TIM:    if (tim_edge) st_nxt = ST_MOVE;
      ST_MOVE: begin
        if (i_motion_done) begin
          st_nxt   = do_pre ? ST_PRESET : ST_IDLE;
          pcnt_nxt = plen_r;
        end
      end
      ST_PRESET: begin
        pcnt_nxt = pcnt_r - 16'h0001;
        if (pcnt_r <= 16'h0001) st_nxt = ST_IDLE;
      end
    endcase
    if (i_panic_stop && seeking) st_nxt = ST_IDLE;
  end

  // commanded position: home zero, then feedback copy, then steps
  assign cpos_nxt = finish ? 32'h0000_0000 :
                    (own_clr | devclr | i_current_off) ? i_fb_pos :
                    i_cmd_step ? (i_cmd_dir ? cpos_r + 32'h1 : cpos_r - 32'h1) : cpos_r;
  assign hv_nxt   = finish | (hv_r & ~seek_go);
  assign dcnt_nxt = drv_clr ? `HSC_DCL_CYC : (dcnt_r != 8'h00) ? dcnt_r - 8'h01 : 8'h00;

  // events and sticky status, set wins over read clear
  assign ev.home_done   = finish;
  assign ev.alarm       = alarm_ev;
  assign ev.limit_found = i_limit_found & seeking;
  assign ev.home_detect = det_ev;
  assign stat_nxt = ((rd & hit(i_wb.adr, `HSC_ADR_STAT)) ? 4'h0 : stat_r) | ev;

  // read data selection
  assign rdata = hit(i_wb.adr, `HSC_ADR_CFG)    ? {21'h0, cfg_r} :
                 hit(i_wb.adr, `HSC_ADR_STAT)   ? {28'h0, stat_r} :
                 hit(i_wb.adr, `HSC_ADR_MASK)   ? {28'h0, mask_r} :
                 hit(i_wb.adr, `HSC_ADR_STATE)  ? {26'h0, st_r, o_at_home, seeking, hv_r} :
                 hit(i_wb.adr, `HSC_ADR_CPOS)   ? cpos_r :
                 hit(i_wb.adr, `HSC_ADR_FPOS)   ? i_fb_pos :
                 hit(i_wb.adr, `HSC_ADR_SOFT_LIMIT_POSITIVE)   ? soft_limit_positive_r :
                 hit(i_wb.adr, `HSC_ADR_SOFT_LIMIT_NEGATIVE)   ? soft_limit_negative_r :
                 hit(i_wb.adr, `HSC_ADR_PRESET) ? {16'h0, plen_r} : 32'h0000_0000;

  // bus slave and software registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
      cfg_r    <= `HSC_CFG_RST;
      mask_r   <= 4'h0;
      soft_limit_positive_r   <= `HSC_SOFT_LIMIT_POSITIVE_RST;
      soft_limit_negative_r   <= `HSC_SOFT_LIMIT_NEGATIVE_RST;
      plen_r   <= `HSC_PRESET_RST;
    end else begin
      o_wb_ack <= req;
      o_wb_dat <= rd ? rdata : 32'h0000_0000;
      if (wr && hit(i_wb.adr, `HSC_ADR_CFG)) begin
        cfg_r <= cfg_m[10:0];
        if (cfg_m[3:0] > `HSC_TYPE_MAX) cfg_r.home_type <= cfg_r.home_type;
      end
      if (wr && hit(i_wb.adr, `HSC_ADR_MASK)) mask_r <= mask_m[3:0];
      if (wr && hit(i_wb.adr, `HSC_ADR_SOFT_LIMIT_POSITIVE)) soft_limit_positive_r <= merge(soft_limit_positive_r, wdat, i_wb.sel);
      if (wr && hit(i_wb.adr, `HSC_ADR_SOFT_LIMIT_NEGATIVE)) soft_limit_negative_r <= merge(soft_limit_negative_r, wdat, i_wb.sel);
      if (wr && hit(i_wb.adr, `HSC_ADR_PRESET)) plen_r <= plen_m[15:0];
    end
  end

  // sequence, position and status state
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_r   <= ST_IDLE;
      pcnt_r <= 16'h0000;
      dcnt_r <= 8'h00;
      cpos_r <= 32'h0000_0000;
      hv_r   <= 1'b0;
      stat_r <= 4'h0;
      {ts1_r, ts2_r, ts3_r} <= 3'h0;
    end else begin
      st_r   <= st_nxt;
      pcnt_r <= pcnt_nxt;
      dcnt_r <= dcnt_nxt;
      cpos_r <= cpos_nxt;
      hv_r   <= hv_nxt;
      stat_r <= stat_nxt;
      {ts1_r, ts2_r, ts3_r} <= {tim_raw, ts1_r, ts2_r};
    end
  end

  // registered outputs
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_irq <= 1'b0;
      {o_seek_start, o_seek_dir, o_at_home, o_driver_pos_reset} <= 4'h0;
      {o_driver_alarm_dev_clear_out, o_feedback_clear} <= 2'h0;
      {o_soft_limit_pos, o_soft_limit_neg, o_system_alarm} <= 3'h0;
    end else begin
      o_irq              <= |(stat_nxt & mask_r);
      o_seek_start       <= seek_go;
      o_seek_dir         <= seek_go ? ~wdat[`HSC_CMD_SEEKN] : o_seek_dir;
      o_at_home          <= cfg_r.at_home_en & hv_nxt & (cpos_nxt == 32'h0);
      o_driver_pos_reset <= st_nxt == ST_PRESET;
      o_driver_alarm_dev_clear_out <= dcnt_nxt != 8'h00;
      o_feedback_clear   <= finish & (cfg_r.dcl_sel == `HSC_DCL_OWN);
      o_soft_limit_pos   <= hv_nxt & ($signed(cpos_nxt) >= $signed(soft_limit_positive_r));
      o_soft_limit_neg   <= hv_nxt & ($signed(cpos_nxt) <= $signed(soft_limit_negative_r));
      o_system_alarm     <= alarm_ev | (o_system_alarm & ~seek_go);
    end
  end

  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence s_move_end;
    st_r == ST_MOVE && i_motion_done && !i_panic_stop;
  endsequence
  AST_HOME_ZERO: assert property (finish |=> cpos_r == 32'h0 && hv_r)
    else $error("position not zeroed at home completion");
  AST_LIMIT_GATED: assert property ((o_soft_limit_pos || o_soft_limit_neg) |-> hv_r)
    else $error("soft limit active without electrical home");
  AST_AT_HOME: assert property (o_at_home |-> cfg_r.at_home_en && cpos_r == 32'h0)
    else $error("at-home output away from home");
  AST_PRESET_ON: assert property ((s_move_end and do_pre) |=> o_driver_pos_reset)
    else $error("driver position reset missing at completion");
  AST_NO_PRESET_12: assert property ((s_move_end and cfg_r.home_type == `HSC_TYPE_SLESS)
    |=> !o_driver_pos_reset)
    else $error("position reset driven in sensorless type");
  AST_ALARM: assert property (alarm_ev |=> o_system_alarm && stat_r.alarm && st_r == ST_IDLE)
    else $error("missing alarm on seek without timing source");
  AST_DCL_BOTH: assert property ((det_ev && cfg_r.dcl_sel == `HSC_DCL_BOTH)
    |=> o_driver_alarm_dev_clear_out [*8])
    else $error("driver clear pulse too short at home detection");
  AST_DCL_NONE: assert property ((stop_ev && sel_none && !o_driver_alarm_dev_clear_out
    && !det_ev) |=> !o_driver_alarm_dev_clear_out)
    else $error("driver cleared with select none");
  AST_DEVIATION_CLEAR_CMD: assert property ((devclr && !finish) |=> cpos_r == $past(i_fb_pos))
    else $error("deviation clear did not copy feedback");
  AST_PRESET_END: assert property ($fell(o_driver_pos_reset) && !$past(i_panic_stop)
    |-> hv_r && stat_r.home_done)
    else $error("completion not reported after position reset");
endmodule : hsc_home_ctrl

/* hsc_pkg.sv */
// types shared by the home seek completion block
// assumes nothing beyond the constants header
package hsc_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_SEEK, ST_TIM, ST_MOVE, ST_PRESET} hsc_state_t;
  typedef struct packed {
    logic       pos_read_en;
    logic       at_home_en;
    logic [1:0] dcl_sel;
    logic       tim_sel;
    logic [1:0] enc_sel;
    logic [3:0] home_type;
  } hsc_cfg_t;
  typedef struct packed {
    logic home_detect;
    logic limit_found;
    logic alarm;
    logic home_done;
  } hsc_evt_t;
  typedef struct packed {
    logic ext_z;
    logic single;
    logic diff;
  } hsc_tim_in_t;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } hsc_wb_req_t;
endpackage : hsc_pkg

/* testbench.sv */
// self-checking bench for the home seek completion block
// assumes the block's register map and the driver model beside it
`timescale 1ns/100ps
`include "hsc_consts.svh"
module testbench;
  import hsc_pkg::*;
  logic        i_clock, i_rst, ack, irq, at_home, pres, dcl, fbclr, soft_limit_positive, alarm;
  logic        cur_off, step, dir, sstart, sdir, soft_limit_negative;
  int          nstart;
  hsc_wb_req_t wb;
  hsc_tim_in_t tim;
  logic [31:0] rdat, fb, v, cp, fp;
  logic [3:0]  evt;
  logic [2:0]  kick;
  logic [7:0]  slip, dn, dl, pn, pl, n0, p0;
  int          err_count, check_count, cyc;
  logic [31:0] cfgs [3] = '{32'h011, 32'h041, 32'h021};
  logic [2:0]  good [3] = '{3'h1, 3'h2, 3'h4};
  logic [2:0]  bad [3] = '{3'h4, 3'h1, 3'h1};

  hsc_home_ctrl hsc_home_ctrl_i (.i_clock(i_clock), .i_rst(i_rst), .i_wb(wb), .o_wb_ack(ack),
    .o_wb_dat(rdat), .o_irq(irq), .i_home_found(evt[0]), .i_limit_found(evt[1]),
    .i_motion_done(evt[2]), .i_panic_stop(evt[3]), .i_current_off(cur_off), .i_cmd_step(step),
    .i_cmd_dir(dir), .i_fb_pos(fb), .i_tim(tim), .o_seek_start(sstart), .o_seek_dir(sdir),
    .o_at_home(at_home), .o_driver_pos_reset(pres), .o_driver_alarm_dev_clear_out(dcl),
    .o_feedback_clear(fbclr), .o_soft_limit_pos(soft_limit_positive), .o_soft_limit_neg(soft_limit_negative),
    .o_system_alarm(alarm));
  hsc_drv_model hsc_drv_model_i (.i_clock(i_clock), .i_rst(i_rst), .i_step(step), .i_dir(dir),
    .i_dcl(dcl), .i_preset(pres), .i_fb_clear(fbclr), .i_z_kick(kick), .i_slip(slip),
    .o_fb_pos(fb), .o_tim(tim), .o_dcl_n(dn), .o_dcl_len(dl), .o_pre_n(pn), .o_pre_len(pl));

  // compare and count
  task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check
  // one classic wishbone cycle, held until ack is sampled
  task wbx(input logic we, input logic [7:0] adr, input logic [31:0] d);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: d};
    do @(posedge i_clock); while (ack !== 1'b1);
    v = rdat;
    wb <= '0;
    @(posedge i_clock);
  endtask : wbx
  task rd(input logic [7:0] adr, input logic [31:0] exp, input string msg);
    wbx(1'b0, adr, 32'h0);
    check(v, exp, msg);
  endtask : rd
  task wt(input int n);
    repeat (n) @(posedge i_clock);
  endtask : wt
  // one-cycle event pulse: {panic, motion done, limit, home found}
  task ev(input logic [3:0] m);
    evt <= m;
    @(posedge i_clock);
    evt <= 4'h0;
  endtask : ev
  task pulse_kick(input logic [2:0] k);
    kick <= k;
    @(posedge i_clock);
    kick <= 3'h0;
  endtask : pulse_kick
  task print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  // hang guard and seek start counter
  always @(posedge i_clock) begin
    cyc++;
    if (sstart === 1'b1) nstart++;
    if (cyc == 6000) begin
      err_count++;
      $display("FAIL %0t timeout", $time);
      print_verdict();
    end
  end

  initial begin
    {i_rst, wb, evt, cur_off, step, dir, kick, slip} = '0;
    i_rst = 1'b1;
    wt(16);
    i_rst <= 1'b0;
    @(posedge i_clock);
    wbx(1'b1, `HSC_ADR_CFG, 32'hd);
    rd(`HSC_ADR_CFG, 32'h0, "cfg reset");
    rd(`HSC_ADR_SOFT_LIMIT_POSITIVE, `HSC_SOFT_LIMIT_POSITIVE_RST, "soft_limit_positive reset");
    rd(`HSC_ADR_SOFT_LIMIT_NEGATIVE, `HSC_SOFT_LIMIT_NEGATIVE_RST, "soft_limit_negative reset");
    rd(8'h3c, 32'h0, "unmapped");
    rd(`HSC_ADR_STATE, 32'h0, "home invalid");
    $display("test reset done");
    // no timing source with a timing home type
    wbx(1'b1, `HSC_ADR_MASK, 32'h2);
    wbx(1'b1, `HSC_ADR_CFG, 32'h1);
    wbx(1'b1, `HSC_ADR_CMD, 32'h1);
    wt(3);
    check({30'h0, alarm, irq}, 32'h3, "alarm irq");
    rd(`HSC_ADR_STAT, 32'h2, "alarm status");
    wt(2);
    check({31'h0, irq}, 32'h0, "irq cleared");
    wbx(1'b1, `HSC_ADR_MASK, 32'h0);
    $display("test alarm done");
    // timing source table: wrong line ignored, right line detects
    for (int k = 0; k < 3; k++) begin
      wbx(1'b1, `HSC_ADR_CFG, cfgs[k]);
      wbx(1'b0, `HSC_ADR_STAT, 32'h0);
      wbx(1'b1, `HSC_ADR_CMD, 32'h1);
      wt(2);
      ev(4'h1);
      pulse_kick(bad[k]);
      wt(8);
      wbx(1'b0, `HSC_ADR_STAT, 32'h0);
      check(v & 32'h8, 32'h0, "wrong timing line");
      pulse_kick(good[k]);
      wt(8);
      wbx(1'b0, `HSC_ADR_STAT, 32'h0);
      check(v & 32'h8, 32'h8, "timing detect");
      ev(4'h4);
      wt(4);
    end
    $display("test timing done");
    // deviation clear selections across a full seek with preset
    for (int s = 0; s < 3; s++) begin
      wbx(1'b1, `HSC_ADR_CFG, 32'h600 | (s << 7));
      dir <= 1'b1;
      slip <= 8'h5;
      @(posedge i_clock);
      slip <= 8'h0;
      wbx(1'b1, `HSC_ADR_CMD, 32'h1);
      wt(2);
      wbx(1'b0, `HSC_ADR_CPOS, 32'h0);
      cp = v;
      wbx(1'b0, `HSC_ADR_FPOS, 32'h0);
      fp = v;
      n0 = dn;
      p0 = pn;
      ev(4'h1);
      wt(30);
      rd(`HSC_ADR_CPOS, s == 2 ? cp : fp, "cpos at detect");
      check({dn - n0, dl}, s == 1 ? {8'h1, 8'd25} : {8'h0, dl}, "driver clear");
      ev(4'h4);
      wt(24);
      check({pn - p0, pl}, {8'h1, 8'h10}, "preset pulse");
      rd(`HSC_ADR_CPOS, 32'h0, "cpos zero");
      if (s == 0) rd(`HSC_ADR_FPOS, 32'h0, "fpos zero");
      wbx(1'b0, `HSC_ADR_STATE, 32'h0);
      check(v & 32'h5, 32'h5, "home valid at home");
      check({31'h0, at_home}, 32'h1, "at home out");
      n0 = dn;
      ev(s == 2 ? 4'h8 : 4'h2);
      wt(30);
      check(dn - n0, s == 2 ? 8'h0 : 8'h1, "limit or stop clear");
    end
    $display("test deviation select done");
    // soft limit acts once home is valid
    wbx(1'b1, `HSC_ADR_SOFT_LIMIT_POSITIVE, 32'h2);
    repeat (3) begin
      step <= 1'b1;
      @(posedge i_clock);
      step <= 1'b0;
      @(posedge i_clock);
    end
    wt(2);
    check({31'h0, soft_limit_positive}, 32'h1, "soft limit");
    wbx(1'b1, `HSC_ADR_SOFT_LIMIT_NEGATIVE, 32'h4);
    wt(2);
    check({31'h0, soft_limit_negative}, 32'h1, "soft limit negative");
    // sensor-less type, negative seek: no preset pulse
    wbx(1'b1, `HSC_ADR_CFG, 32'h40c);
    wbx(1'b1, `HSC_ADR_CMD, 32'h2);
    wt(2);
    p0 = pn;
    ev(4'h1);
    ev(4'h4);
    wt(24);
    check(pn - p0, 8'h0, "no preset");
    rd(`HSC_ADR_CPOS, 32'h0, "sensorless zero");
    rd(`HSC_ADR_FPOS, fb, "position read after home");
    check(nstart, 32'd7, "seek starts");
    check({31'h0, sdir}, 32'h0, "seek direction negative");
    // deviation clear command and current-off tracking
    slip <= 8'h7;
    @(posedge i_clock);
    slip <= 8'h0;
    wbx(1'b1, `HSC_ADR_CMD, 32'h4);
    wt(2);
    rd(`HSC_ADR_CPOS, fb, "devclr cmd");
    cur_off <= 1'b1;
    slip <= 8'h9;
    @(posedge i_clock);
    slip <= 8'h0;
    wt(4);
    rd(`HSC_ADR_CPOS, fb, "current off track");
    cur_off <= 1'b0;
    $display("test position done");
    print_verdict();
  end
endmodule : testbench
